// [hdl/motion_set_pkg.sv]
// Constants and types for the motion set table
package motion_set_pkg;
    localparam int NUM_ROWS = 32;
    localparam int NUM_COLS = 9;
    localparam int ROW_W = 6;
    localparam int COL_W = 4;
    localparam int DATA_W = 32;
    // Column object number range and column indices
    localparam logic [15:0] COL_OBJ_BASE = 16'h076D;
    localparam logic [15:0] COL_OBJ_LAST = 16'h0775;
    localparam logic [3:0] COL_POSITION = 4'h1;
    localparam logic [3:0] COL_SPEED = 4'h2;
    localparam logic [3:0] COL_RSVD_A = 4'h3;
    localparam logic [3:0] COL_FLAGS = 4'h4;
    localparam logic [3:0] COL_FUNC = 4'h5;
    localparam logic [3:0] COL_ACCEL = 4'h6;
    localparam logic [3:0] COL_DECEL = 4'h7;
    localparam logic [3:0] COL_JERK = 4'h8;
    localparam logic [3:0] COL_RSVD_B = 4'h9;
    // Flag byte fields
    localparam int FLAG_VAL_LSB = 0;
    localparam int FLAG_EN_LSB = 4;
    localparam int NUM_FLAGS = 3;
    // Status word 2 flag position
    localparam int STAT2_FLAG_LSB = 12;
    // Control word 1 start bit
    localparam int CTRL1_START_BIT = 4;

    typedef enum logic [2:0] {
        FUNC_NONE = 3'b000,
        FUNC_ABSOLUTE_MOVE = 3'b001,
        FUNC_RELATIVE_MOVE = 3'b010,
        FUNC_GEARING = 3'b011,
        FUNC_MARK_SEARCH = 3'b100,
        FUNC_MARK_OFFSET_MOVE = 3'b101,
        FUNC_VELOCITY = 3'b110,
        FUNC_STOP = 3'b111
    } func_e;

    typedef struct packed {
        logic [31:0] target;
        logic [31:0] speed;
        logic [31:0] accel;
        logic [31:0] decel;
        logic [31:0] jerk;
        logic [31:0] gear_num;
        logic [31:0] gear_den;
        logic use_target;
        logic use_speed;
        logic use_accel;
        logic use_decel;
        logic use_jerk;
    } motion_cmd_s;

    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] obj;
        logic [ROW_W-1:0] index;
        logic [31:0] wdata;
    } msg_req_s;
endpackage

// [hdl/motion_set_table.sv]
// Motion set table: storage, mode decoding and user flag handling
// Functional notes
// - Table of nine columns, thirty-two rows
// - Element addressed by column object and row
// - Column 5 function code selects column meaning
// - Columns 3 and 9 reserved, unused
// - Codes 1,2: position, speed, accel, decel, jerk
// - Code 3 gearing: numerator, denominator, acceleration
// - Code 6 velocity: speed and acceleration only
// - Codes 4,5,7: search, offset move, stop
// - Column 4 holds flag values and enables
// - On completion copy enabled flag values
// - Disabled flags keep previous value
// - Flags appear at status word 2 bits 12-14
// - Control word 1 bit 4 starts set
`timescale 1ns/10ps
module motion_set_table #(
    parameter int ROWS = motion_set_pkg::NUM_ROWS
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire motion_set_pkg::msg_req_s msg_in,
    output logic msg_ack_out,
    output logic msg_err_out,
    output logic [31:0] msg_rdata_out,
    input wire logic [15:0] ctrl_word1_in,
    input wire logic [15:0] ctrl_word2_in,
    input wire logic motion_done_in,
    output logic motion_start_out,
    output motion_set_pkg::func_e motion_func_out,
    output motion_set_pkg::motion_cmd_s motion_cmd_out,
    output logic [15:0] status_word2_out
);
    import motion_set_pkg::*;

    // Refuse row counts the index decode cannot serve
    if (ROWS < 1 || ROWS > NUM_ROWS)
    begin
        $error("ROWS out of range");
    end

    // Row storage, one array per column; reserved columns are storage only
    logic [31:0] col_pos_q [1:ROWS];
    logic [31:0] col_spd_q [1:ROWS];
    logic [15:0] col_rsa_q [1:ROWS];
    logic [15:0] col_flg_q [1:ROWS];
    logic [15:0] col_fun_q [1:ROWS];
    logic [31:0] col_acc_q [1:ROWS];
    logic [31:0] col_dec_q [1:ROWS];
    logic [31:0] col_jrk_q [1:ROWS];
    logic [31:0] col_rsb_q [1:ROWS];

    // Decode column object and row index
    logic [3:0] col_sel;
    logic addr_ok;
    always_comb
    begin
        col_sel = 4'(msg_in.obj - COL_OBJ_BASE + 16'h0001);
        addr_ok = (msg_in.obj >= COL_OBJ_BASE) && (msg_in.obj <= COL_OBJ_LAST)
            && (msg_in.index != '0) && (32'(msg_in.index) <= ROWS);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (msg_in.req && msg_in.wr && addr_ok)
        begin
            unique case (col_sel)
                COL_POSITION: col_pos_q[msg_in.index] <= msg_in.wdata;
                COL_SPEED: col_spd_q[msg_in.index] <= msg_in.wdata;
                COL_RSVD_A: col_rsa_q[msg_in.index] <= msg_in.wdata[15:0];
                COL_FLAGS: col_flg_q[msg_in.index] <= msg_in.wdata[15:0];
                COL_FUNC: col_fun_q[msg_in.index] <= msg_in.wdata[15:0];
                COL_ACCEL: col_acc_q[msg_in.index] <= msg_in.wdata;
                COL_DECEL: col_dec_q[msg_in.index] <= msg_in.wdata;
                COL_JERK: col_jrk_q[msg_in.index] <= msg_in.wdata;
                COL_RSVD_B: col_rsb_q[msg_in.index] <= msg_in.wdata;
                default: ;
            endcase
        end
    end

    logic [31:0] rdata_d;
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (addr_ok)
        begin
            unique case (col_sel)
                COL_POSITION: rdata_d = col_pos_q[msg_in.index];
                COL_SPEED: rdata_d = col_spd_q[msg_in.index];
                COL_RSVD_A: rdata_d = {16'h0000, col_rsa_q[msg_in.index]};
                COL_FLAGS: rdata_d = {16'h0000, col_flg_q[msg_in.index]};
                COL_FUNC: rdata_d = {16'h0000, col_fun_q[msg_in.index]};
                COL_ACCEL: rdata_d = col_acc_q[msg_in.index];
                COL_DECEL: rdata_d = col_dec_q[msg_in.index];
                COL_JERK: rdata_d = col_jrk_q[msg_in.index];
                COL_RSVD_B: rdata_d = col_rsb_q[msg_in.index];
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            msg_ack_out <= 1'b0;
            msg_err_out <= 1'b0;
            msg_rdata_out <= 32'h0000_0000;
        end
        else
        begin
            msg_ack_out <= msg_in.req;
            msg_err_out <= msg_in.req && !addr_ok;
            if (msg_in.req && !msg_in.wr)
            begin
                msg_rdata_out <= rdata_d;
            end
        end
    end

    // Start on rising edge of control word 1 start bit
    logic start_lvl_q;
    logic start_evt;
    logic [ROW_W-1:0] sel_row;
    logic sel_ok;
    always_comb
    begin
        sel_row = ctrl_word2_in[ROW_W-1:0];
        sel_ok = (ctrl_word2_in[15:ROW_W] == '0) && (sel_row != '0)
            && (32'(sel_row) <= ROWS);
        start_evt = ctrl_word1_in[CTRL1_START_BIT] && !start_lvl_q && sel_ok;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            start_lvl_q <= 1'b0;
        end
        else
        begin
            start_lvl_q <= ctrl_word1_in[CTRL1_START_BIT];
        end
    end

    // Decode selected row by its function code
    func_e func_d;
    motion_cmd_s cmd_d;
    always_comb
    begin
        cmd_d = '0;
        func_d = FUNC_NONE;
        if (col_fun_q[sel_row] >= 16'h0001 && col_fun_q[sel_row] <= 16'h0007)
        begin
            func_d = func_e'(col_fun_q[sel_row][2:0]);
        end
        unique case (func_d)
            FUNC_ABSOLUTE_MOVE, FUNC_RELATIVE_MOVE, FUNC_MARK_SEARCH:
            begin
                cmd_d.target = col_pos_q[sel_row];
                cmd_d.speed = col_spd_q[sel_row];
                cmd_d.accel = col_acc_q[sel_row];
                cmd_d.decel = col_dec_q[sel_row];
                cmd_d.jerk = col_jrk_q[sel_row];
                cmd_d.use_target = 1'b1;
                cmd_d.use_speed = 1'b1;
                cmd_d.use_accel = 1'b1;
                cmd_d.use_decel = 1'b1;
                cmd_d.use_jerk = 1'b1;
            end
            FUNC_GEARING:
            begin
                cmd_d.gear_num = col_spd_q[sel_row];
                cmd_d.gear_den = col_dec_q[sel_row];
                cmd_d.accel = col_acc_q[sel_row];
                cmd_d.use_accel = 1'b1;
            end
            FUNC_MARK_OFFSET_MOVE:
            begin
                cmd_d.target = col_pos_q[sel_row];
                cmd_d.speed = col_spd_q[sel_row];
                cmd_d.use_target = 1'b1;
                cmd_d.use_speed = 1'b1;
            end
            FUNC_VELOCITY:
            begin
                cmd_d.speed = col_spd_q[sel_row];
                cmd_d.accel = col_acc_q[sel_row];
                cmd_d.use_speed = 1'b1;
                cmd_d.use_accel = 1'b1;
            end
            FUNC_STOP:
            begin
                cmd_d.decel = col_dec_q[sel_row];
                cmd_d.jerk = col_jrk_q[sel_row];
                cmd_d.use_decel = 1'b1;
                cmd_d.use_jerk = 1'b1;
            end
            FUNC_NONE: ;
        endcase
    end

    // Latched flag byte of the running set
    logic [7:0] run_flags_q;
    logic running_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            motion_start_out <= 1'b0;
            motion_func_out <= FUNC_NONE;
            motion_cmd_out <= '0;
            run_flags_q <= 8'h00;
            running_q <= 1'b0;
        end
        else
        begin
            motion_start_out <= start_evt && (func_d != FUNC_NONE);
            if (start_evt && func_d != FUNC_NONE)
            begin
                motion_func_out <= func_d;
                motion_cmd_out <= cmd_d;
                run_flags_q <= col_flg_q[sel_row][7:0];
                running_q <= 1'b1;
            end
            else if (motion_done_in)
            begin
                running_q <= 1'b0;
            end
        end
    end

    // User flags into status word 2
    logic [NUM_FLAGS-1:0] user_flag_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            user_flag_q <= '0;
        end
        else if (motion_done_in && running_q)
        begin
            for (int i = 0; i < NUM_FLAGS; i++)
            begin
                if (run_flags_q[FLAG_EN_LSB + i])
                begin
                    user_flag_q[i] <= run_flags_q[FLAG_VAL_LSB + i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            status_word2_out <= 16'h0000;
        end
        else
        begin
            status_word2_out <= 16'(user_flag_q) << STAT2_FLAG_LSB;
        end
    end

    a_flag_copy: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (motion_done_in && running_q && run_flags_q[FLAG_EN_LSB])
        |=> user_flag_q[0] == $past(run_flags_q[FLAG_VAL_LSB]))
        else $error("enabled flag not copied");
    a_flag_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (!run_flags_q[FLAG_EN_LSB + 1]) |=> $stable(user_flag_q[1]))
        else $error("disabled flag changed");
    a_status_map: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        1'b1 |=> status_word2_out[14:12] == $past(user_flag_q))
        else $error("status word 2 flag map wrong");
    a_start_edge: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        motion_start_out |-> $past(ctrl_word1_in[CTRL1_START_BIT])
        && !$past(start_lvl_q))
        else $error("start without rising edge");
    a_gear_map: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (motion_start_out && motion_func_out == FUNC_GEARING)
        |-> !motion_cmd_out.use_target && !motion_cmd_out.use_jerk)
        else $error("gearing uses unused column");
    a_velocity_map: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (motion_start_out && motion_func_out == FUNC_VELOCITY)
        |-> motion_cmd_out.use_speed && !motion_cmd_out.use_decel)
        else $error("velocity mapping wrong");
    a_stop_map: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (motion_start_out && motion_func_out == FUNC_STOP)
        |-> !motion_cmd_out.use_speed && motion_cmd_out.use_decel)
        else $error("stop mapping wrong");
    a_abs_map: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (motion_start_out && motion_func_out == FUNC_ABSOLUTE_MOVE)
        |-> motion_cmd_out.use_target && motion_cmd_out.use_jerk)
        else $error("absolute move mapping wrong");
    a_addr_err: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (msg_in.req && msg_in.index == '0) |=> msg_ack_out && msg_err_out)
        else $error("row 0 not refused");
    a_rdata_refused: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (msg_in.req && !msg_in.wr && !addr_ok) |=> msg_rdata_out == 32'h0000_0000)
        else $error("refused read returned data");
    a_func_valid: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        motion_start_out |-> motion_func_out != FUNC_NONE)
        else $error("start with illegal function code");
endmodule

// [verif/master_model.sv]
// Fieldbus master model: explicit messages and cyclic control words
`timescale 1ns/10ps
module master_model (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic err_in,
    input wire logic [31:0] rdata_in,
    output motion_set_pkg::msg_req_s msg_out,
    output logic [15:0] ctrl_word1_out,
    output logic [15:0] ctrl_word2_out
);
    import motion_set_pkg::*;
    initial
    begin
        msg_out = '0;
        ctrl_word1_out = 16'h0000;
        ctrl_word2_out = 16'h0000;
    end
    // One-cycle request; idle fields inverted so stale data never looks valid
    task automatic xfer(input logic wr, input logic [15:0] obj, input logic [5:0] idx,
        input logic [31:0] wd, output logic ack, output logic err, output logic [31:0] rd);
        @(posedge clk_in);
        msg_out <= '{req: 1'b1, wr: wr, obj: obj, index: idx, wdata: wd};
        @(posedge clk_in);
        msg_out <= '{req: 1'b0, wr: ~wr, obj: ~obj, index: ~idx, wdata: ~wd};
        // Answer is registered: taken at the edge where ack stands high
        @(posedge clk_in);
        ack = ack_in;
        err = err_in;
        rd = rdata_in;
    endtask
    task automatic start_set(input logic [15:0] set_no);
        @(posedge clk_in);
        ctrl_word2_out <= set_no;
        ctrl_word1_out <= 16'h0010;
    endtask
    task automatic release_start();
        @(posedge clk_in);
        ctrl_word1_out <= 16'h0000;
    endtask
endmodule

// [verif/testbench.sv]
// Self-checking bench for the motion set table
`timescale 1ns/10ps
module testbench;
    import motion_set_pkg::*;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic motion_done_in = 1'b0;
    msg_req_s msg_in;
    logic [15:0] ctrl_word1_in;
    logic [15:0] ctrl_word2_in;
    logic msg_ack_out;
    logic msg_err_out;
    logic motion_start_out;
    logic [31:0] msg_rdata_out;
    func_e motion_func_out;
    motion_cmd_s motion_cmd_out;
    logic [15:0] status_word2_out;
    logic a;
    logic e;
    logic [31:0] r;
    int mismatches = 0;
    int cmp_count = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    master_model mm (.clk_in(clk_sys_in), .ack_in(msg_ack_out), .err_in(msg_err_out),
        .rdata_in(msg_rdata_out), .msg_out(msg_in), .ctrl_word1_out(ctrl_word1_in),
        .ctrl_word2_out(ctrl_word2_in));
    motion_set_table #(.ROWS(32)) dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .msg_in(msg_in), .msg_ack_out(msg_ack_out), .msg_err_out(msg_err_out),
        .msg_rdata_out(msg_rdata_out), .ctrl_word1_in(ctrl_word1_in),
        .ctrl_word2_in(ctrl_word2_in), .motion_done_in(motion_done_in),
        .motion_start_out(motion_start_out), .motion_func_out(motion_func_out),
        .motion_cmd_out(motion_cmd_out), .status_word2_out(status_word2_out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [31:0] vv(int f, int c);
        return 32'hC000_0000 | 32'(f * 256 + c);
    endfunction
    task automatic wr(input logic [3:0] col, input logic [5:0] row, input logic [31:0] d);
        mm.xfer(1'b1, 16'h076C + {12'h000, col}, row, d, a, e, r);
    endtask
    task automatic no_start(input int n);
        repeat (n)
        begin
            @(posedge clk_sys_in);
            #1;
            chk({31'h0, motion_start_out}, 32'h0, "no start");
        end
    endtask
    task automatic t_storage();
        logic [31:0] d;
        for (int p = 0; p < 2; p++)
            for (int row = 1; row <= 32; row += 31)
                for (int c = 1; c <= 9; c++)
                begin
                    d = 32'hB7E1_0000 | 32'(row * 256 + c);
                    mm.xfer(1'(p == 0), 16'h076C + 16'(c), 6'(row), d, a, e, r);
                    chk({31'h0, a}, 32'h1, "ack");
                    chk({31'h0, e}, 32'h0, "err");
                    if (p == 1)
                        chk(r, (c inside {3, 4, 5}) ? {16'h0, d[15:0]} : d, "read");
                end
        $display("test storage done");
    endtask
    task automatic t_bad_addr();
        logic [15:0] objs [4] = '{16'h076C, 16'h0776, 16'h0770, 16'h0770};
        logic [5:0] idxs [4] = '{6'h01, 6'h01, 6'h00, 6'h21};
        for (int i = 0; i < 4; i++)
        begin
            mm.xfer(1'(i != 1), objs[i], idxs[i], 32'h0000_0000, a, e, r);
            chk({30'h0, a, e}, 32'h3, "bad ack err");
            if (i == 1)
                chk(r, 32'h0, "bad rdata");
        end
        mm.xfer(1'b0, 16'h0770, 6'h01, 32'h0, a, e, r);
        chk(r, 32'h0000_0104, "no store");
        $display("test bad address done");
    endtask
    task automatic t_modes();
        logic [4:0] use_exp [8] = '{5'h00, 5'h1F, 5'h1F, 5'h04, 5'h1F, 5'h18, 5'h0C, 5'h03};
        logic [4:0] care;
        logic [4:0] got;
        logic [15:0] bad_sets [3] = '{16'h0000, 16'h0021, 16'h0041};
        for (int f = 1; f <= 7; f++)
        begin
            for (int c = 1; c <= 9; c++)
                wr(4'(c), 6'(f), c == 5 ? 32'(f) : (c == 4 ? 32'h0 : vv(f, c)));
            mm.start_set(16'(f));
            @(posedge clk_sys_in);
            #1;
            chk({31'h0, motion_start_out}, 32'h1, "start");
            chk({29'h0, motion_func_out}, 32'(f), "func");
            care = (f == 3) ? 5'h15 : 5'h1F;
            got = {motion_cmd_out.use_target, motion_cmd_out.use_speed,
                motion_cmd_out.use_accel, motion_cmd_out.use_decel, motion_cmd_out.use_jerk};
            chk({27'h0, got & care}, {27'h0, use_exp[f] & care}, "use");
            if (use_exp[f][4])
                chk(motion_cmd_out.target, vv(f, 1), "target");
            if (use_exp[f][3])
                chk(motion_cmd_out.speed, vv(f, 2), "speed");
            if (use_exp[f][2])
                chk(motion_cmd_out.accel, vv(f, 6), "accel");
            if (use_exp[f][1])
                chk(motion_cmd_out.decel, vv(f, 7), "decel");
            if (use_exp[f][0])
                chk(motion_cmd_out.jerk, vv(f, 8), "jerk");
            if (f == 3)
            begin
                chk(motion_cmd_out.gear_num, vv(f, 2), "gear num");
                chk(motion_cmd_out.gear_den, vv(f, 7), "gear den");
            end
            no_start(3);
            mm.release_start();
        end
        for (int s = 8; s <= 9; s++)
        begin
            wr(4'h5, 6'(s), s == 8 ? 32'h0 : 32'h8);
            mm.start_set(16'(s));
            no_start(3);
            mm.release_start();
        end
        for (int k = 0; k < 3; k++)
        begin
            mm.start_set(bad_sets[k]);
            no_start(3);
            mm.release_start();
        end
        $display("test modes done");
    endtask
    task automatic t_flags();
        logic [7:0] bytes [2] = '{8'h77, 8'hA9};
        logic [15:0] exp [2] = '{16'h7000, 16'h5000};
        for (int i = 0; i < 2; i++)
        begin
            wr(4'h5, 6'(10 + i), i == 0 ? 32'h1 : 32'h7);
            wr(4'h4, 6'(10 + i), {24'h0, bytes[i]});
            mm.start_set(16'(10 + i));
            @(posedge clk_sys_in);
            #1;
            chk({31'h0, motion_start_out}, 32'h1, "start");
            mm.release_start();
            motion_done_in <= 1'b1;
            @(posedge clk_sys_in);
            motion_done_in <= 1'b0;
            repeat (2) @(posedge clk_sys_in);
            #1;
            chk({16'h0, status_word2_out}, {16'h0, exp[i]}, "flags");
        end
        $display("test flags done");
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys_in);
        chk({15'h0, motion_start_out, status_word2_out}, 32'h0, "reset");
        resetn_in <= 1'b1;
        t_storage();
        t_bad_addr();
        t_modes();
        t_flags();
        finish_test();
    end
    initial
    begin
        #2000000;
        mismatches++;
        $display("ERROR %0t: run timed out", $time);
        finish_test();
    end
endmodule
